// ==== hw/synth_host.sv ====
// host controller: avalon-mm slave for software, serial master toward the device,
// sync pulse driver on the multipurpose pin with guards on the register setup
// assumes software follows the sync sequence; the guards only block the pin
`timescale 1ns/1ps
module synth_host (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  synth_link_if.host_end link
);
  // ==========================================================
  // state
  typedef enum logic [1:0] {
    IDLE = 2'b00,
    SHIFT = 2'b01,
    LATCH = 2'b10,
    READ = 2'b11
  } host_phase_type;
  typedef struct packed {
    host_phase_type st;
    logic [7:0] tick_count;
    logic sclk;
    logic le;
    logic [31:0] shift;
    logic [5:0] bit_count;
    logic readback;
    logic [31:0] rx;
    logic [1:0] ctrl;
    logic mux_out;
    logic mux_oe;
    logic [5:0][31:0] shadow;
    logic sync_ok;
    logic ack;
    logic [31:0] rdata;
  } host_state_type;
  host_state_type s;
  host_state_type next_s;

  always_comb begin
    logic tick;
    logic busy;
    logic target;
    logic [15:0] n_ratio;
    tick = (s.tick_count == synth_pkg::SCLK_HALF_CYCLES);
    busy = (s.st != IDLE);
    target = 1'b0;
    n_ratio = s.shadow[0][synth_pkg::N_HI:synth_pkg::N_LO];
    next_s = s;
    next_s.tick_count = tick ? 8'h00 : s.tick_count + 8'h01;
    // ========================================================
    // avalon slave: one wait cycle, longer for a tx write while the engine shifts, latches or reads back a word
    next_s.ack = 1'b0;
    if ((read || write) && !s.ack && !(write && address == synth_pkg::HOST_TX && busy)) begin
      next_s.ack = 1'b1;
      next_s.rdata = '0;
      if (read) begin
        unique case (address)
          synth_pkg::HOST_CTRL: next_s.rdata = {30'h0000_0000, s.ctrl};
          synth_pkg::HOST_STATUS: next_s.rdata = {28'h000_0000, s.sync_ok, link.mux_level,
            link.lock_detect, busy};
          synth_pkg::HOST_RX: next_s.rdata = s.rx;
          default: next_s.rdata = '0;
        endcase
      end else if (address == synth_pkg::HOST_TX) begin
        next_s.shift = writedata;
        next_s.bit_count = '0;
        next_s.readback = (writedata[2:0] == synth_pkg::ADDR_REG6);
        if (writedata[2:0] <= synth_pkg::ADDR_LAST_WRITABLE) begin
          next_s.shadow[writedata[2:0]] = writedata;
        end
        next_s.st = SHIFT;
        next_s.tick_count = '0;
      end else if (address == synth_pkg::HOST_CTRL) begin
        next_s.ctrl = writedata[1:0];
      end
    end
    // ========================================================
    // serial engine, msb first, data changes while sclk is low
    if (tick) begin
      unique case (s.st)
        IDLE: begin
          next_s.sclk = 1'b0;
        end
        SHIFT: begin
          if (!s.sclk) begin
            next_s.sclk = 1'b1;
          end else begin
            next_s.sclk = 1'b0;
            next_s.shift = {s.shift[30:0], 1'b0};
            next_s.bit_count = s.bit_count + 6'h01;
            if (s.bit_count == synth_pkg::WORD_BITS_COUNT - 6'h01) begin
              next_s.st = LATCH;
            end
          end
        end
        LATCH: begin
          next_s.le = ~s.le;
          next_s.bit_count = '0;
          if (s.le) begin
            next_s.st = s.readback ? READ : IDLE;
          end
        end
        READ: begin
          // the device moves its bit on our rising edge, so sample before it
          if (!s.sclk) begin
            next_s.rx = {s.rx[30:0], link.mux_level};
            next_s.sclk = 1'b1;
          end else begin
            next_s.sclk = 1'b0;
            next_s.bit_count = s.bit_count + 6'h01;
            if (s.bit_count == synth_pkg::WORD_BITS_COUNT - 6'h01) begin
              next_s.st = IDLE;
            end
          end
        end
      endcase
    end
    // ========================================================
    // sync setup guard over the shadow copies of what was sent
    next_s.sync_ok = ~s.shadow[2][synth_pkg::DOUBLER_BIT]
      & ~s.shadow[2][synth_pkg::HALVING_BIT]
      & (s.shadow[2][synth_pkg::RDIV_HI:synth_pkg::RDIV_LO] == synth_pkg::RDIV_ONE)
      & ~s.shadow[0][synth_pkg::INT_MODE_BIT]
      & ~s.shadow[5][synth_pkg::ZERO_FRAC_BIT]
      & ~s.shadow[4][synth_pkg::FEEDBACK_BIT]
      & ~s.shadow[4][synth_pkg::SECOND_SRC_BIT]
      & (s.shadow[2][synth_pkg::NOISE_HI:synth_pkg::NOISE_LO] == 2'h0)
      & (n_ratio > synth_pkg::N_MIN_EXCL) & (n_ratio < synth_pkg::N_MAX_EXCL)
      & (s.shadow[4][synth_pkg::OUT_DIV_HI:synth_pkg::OUT_DIV_LO] <= synth_pkg::OUT_DIV_MAX)
      & s.shadow[3][synth_pkg::AUTOSEL_DISABLE_BIT]
      & ({s.shadow[5][synth_pkg::PIN_FN_MSB_BIT],
        s.shadow[2][synth_pkg::PIN_FN_HI:synth_pkg::PIN_FN_LO]} == synth_pkg::PIN_FN_SYNC);
    // ========================================================
    // pin drive: high only once locked and set up; low before release
    target = s.ctrl[synth_pkg::CTRL_LEVEL_BIT] & link.lock_detect & s.sync_ok;
    if (s.ctrl[synth_pkg::CTRL_DRIVE_BIT]) begin
      next_s.mux_oe = 1'b1;
      next_s.mux_out = target;
    end else if (s.mux_out) begin
      next_s.mux_out = 1'b0;
    end else begin
      next_s.mux_oe = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================
  // outputs
  assign readdata = s.rdata;
  assign waitrequest = ~s.ack;
  assign link.sclk = s.sclk;
  assign link.sdata = s.shift[31];
  assign link.le = s.le;
  assign link.host_mux_out = s.mux_out;
  assign link.host_mux_oe = s.mux_oe;
endmodule : synth_host

// ==== include/synth_pkg.sv ====
// constants shared by the synthesizer device model, its host controller and the link
// assumes one 50 MHz clock that also stands for the shared reference input
package synth_pkg;
  // ==========================================================
  // clock and timing
  localparam int CLK_MHZ = 50;
  localparam int SEARCH_TIME_US = 200;
  localparam int SEARCH_CYCLES = SEARCH_TIME_US * CLK_MHZ;
  localparam int LOCK_TIME_US = 20;
  localparam int LOCK_CYCLES = LOCK_TIME_US * CLK_MHZ;
  localparam logic [7:0] SCLK_HALF_CYCLES = 8'h04;
  // ==========================================================
  // serial word layout
  localparam int WORD_BITS = 32;
  localparam logic [5:0] WORD_BITS_COUNT = 6'h20;
  localparam logic [2:0] ADDR_REG0 = 3'h0;
  localparam logic [2:0] ADDR_REG6 = 3'h6;
  localparam logic [2:0] ADDR_LAST_WRITABLE = 3'h5;
  // ==========================================================
  // field positions
  localparam int INT_MODE_BIT = 31;
  localparam int N_HI = 30;
  localparam int N_LO = 15;
  localparam int PHASE_HI = 26;
  localparam int PHASE_LO = 15;
  localparam int NOISE_HI = 30;
  localparam int NOISE_LO = 29;
  localparam int PIN_FN_HI = 28;
  localparam int PIN_FN_LO = 26;
  localparam int DOUBLER_BIT = 25;
  localparam int HALVING_BIT = 24;
  localparam int RDIV_HI = 23;
  localparam int RDIV_LO = 14;
  localparam int OSC_HI = 31;
  localparam int OSC_LO = 26;
  localparam int AUTOSEL_DISABLE_BIT = 25;
  localparam int DIV_MODE_HI = 16;
  localparam int DIV_MODE_LO = 15;
  localparam int FEEDBACK_BIT = 23;
  localparam int OUT_DIV_HI = 22;
  localparam int OUT_DIV_LO = 20;
  localparam int SECOND_SRC_BIT = 9;
  localparam int ZERO_FRAC_BIT = 24;
  localparam int PIN_FN_MSB_BIT = 18;
  // ==========================================================
  // field values
  localparam logic [3:0] PIN_FN_HIZ = 4'h0;
  localparam logic [3:0] PIN_FN_SYNC = 4'h7;
  localparam logic [3:0] PIN_FN_READBACK = 4'hc;
  localparam logic [1:0] DIV_MODE_OFF = 2'h0;
  localparam logic [1:0] DIV_MODE_PHASE = 2'h2;
  localparam logic [9:0] RDIV_ONE = 10'h001;
  localparam logic [15:0] N_MIN_EXCL = 16'h0013;
  localparam logic [15:0] N_MAX_EXCL = 16'h0ffb;
  localparam logic [2:0] OUT_DIV_MAX = 3'h4;
  localparam logic [3:0] DIE_ID = 4'h5; // arbitrary value
  // ==========================================================
  // host register offsets (byte addresses)
  localparam logic [3:0] HOST_TX = 4'h0;
  localparam logic [3:0] HOST_CTRL = 4'h4;
  localparam logic [3:0] HOST_STATUS = 4'h8;
  localparam logic [3:0] HOST_RX = 4'hc;
  localparam int CTRL_DRIVE_BIT = 0;
  localparam int CTRL_LEVEL_BIT = 1;
endpackage : synth_pkg

// ==== include/synth_link_if.sv ====
// 3-wire serial link plus lock-detect and the shared two-way multipurpose pin
// assumes both ends run on the same clock; pins are synchronous to it
`timescale 1ns/1ps
interface synth_link_if;
  logic sclk;
  logic sdata;
  logic le;
  logic lock_detect;
  logic host_mux_out;
  logic host_mux_oe;
  logic dev_mux_out;
  logic dev_mux_oe;
  logic mux_level;
  // host drive wins; an undriven pin reads low
  assign mux_level = host_mux_oe ? host_mux_out : (dev_mux_oe ? dev_mux_out : 1'b0);
  modport host_end (output sclk, output sdata, output le, output host_mux_out,
    output host_mux_oe, input lock_detect, input mux_level);
  modport device_end (input sclk, input sdata, input le, output dev_mux_out,
    output dev_mux_oe, output lock_detect, input mux_level);
endinterface : synth_link_if

// ==== hw/rise_detect.sv ====
// rising edge finder for a pin that is already synchronous to clk
// assumes clk and synchronous active-low rstn
`timescale 1ns/1ps
module rise_detect (
  input wire logic clk,
  input wire logic rstn,
  input wire logic level,
  output logic rise
);
  typedef struct packed {
    logic prev;
  } rise_state_type;
  rise_state_type s;
  rise_state_type next_s;
  always_comb begin
    next_s = s;
    next_s.prev = level;
  end
  always_ff @(posedge clk) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
  assign rise = level & ~s.prev;
endmodule : rise_detect

// ==== hw/synth_device.sv ====
// behavioural model of the synthesizer's digital side: serial registers,
// oscillator selection, lock indication, readback and output phase sync
// assumes the link pins are synchronous to clk; clk stands for the reference
// Behaviour
// - autoselect disabled: use host oscillator index
// - host reads current oscillator via pin
// - host builds lookup table once per power
// - index to reg3, then reg0 write retunes
// - sync only honoured in fractional mode
// - host clears doubler and halving bits
// - host sets reference divider to one
// - host clears integer and zero-fraction bits
// - host clears feedback source select
// - host clears second output source select
// - host sets modulator noise mode 00
// - host keeps feedback ratio in 20..4090
// - host keeps first divider at most 16
// - pin function 0111 makes pin sync input
// - locked devices resync on pin rising edge
// - host lowers pin, sets hiz, then releases
// - host then writes only phase values
// - divider mode 10 then 00 applies phase
// - host repeats sequence per new frequency
// - shared reference, autoselect disabled during sync
`timescale 1ns/1ps
module synth_device #(
  parameter int SEARCH_CYCLES = synth_pkg::SEARCH_CYCLES
) (
  input wire logic clk,
  input wire logic rstn,
  synth_link_if.device_end link,
  output logic locked,
  output logic [5:0] osc_index,
  output logic [11:0] output_phase,
  output logic synced,
  output logic phase_applied
);
  // ==========================================================
  // state
  typedef struct packed {
    logic [5:0][31:0] regs;
    logic [31:0] shift_in;
    logic [31:0] shift_out;
    // readback bits still to send
    logic [5:0] out_count;
    // counts down search time, then lock time
    logic [15:0] timer;
    // high while the band search runs
    logic searching;
    logic locked;
    logic [5:0] osc;
    logic [11:0] phase;
    logic synced;
    logic phase_applied;
    // previous divider mode, to see the step from 10 to 00
    logic [1:0] last_div_mode;
    // high only while the pin function is the readback code
    logic mux_oe;
  } dev_state_type;
  dev_state_type s;
  dev_state_type next_s;
  logic sclk_rise;
  logic le_rise;
  logic mux_rise;

  // ==========================================================
  // pin edges
  // the pins are synchronous already, so one flop per edge will do
  rise_detect sclk_edge (
    .clk(clk),
    .rstn(rstn),
    .level(link.sclk),
    .rise(sclk_rise)
  );
  rise_detect le_edge (
    .clk(clk),
    .rstn(rstn),
    .level(link.le),
    .rise(le_rise)
  );
  rise_detect mux_edge (
    .clk(clk),
    .rstn(rstn),
    .level(link.mux_level),
    .rise(mux_rise)
  );

  // ==========================================================
  // next state
  always_comb begin
    logic [3:0] pin_fn;
    logic [1:0] div_mode;
    logic [31:0] word6;
    logic fractional;
    next_s = s;
    pin_fn = '0;
    div_mode = '0;
    word6 = '0;
    fractional = 1'b0;

    // ========================================================
    // divider phase
    // free-running output divider phase stands in for the rf output
    next_s.phase = s.phase + 12'h001;

    // ========================================================
    // lock timing
    // the search ends lock_cycles minus one clocks before lock is flagged
    if (s.timer != '0) begin
      next_s.timer = s.timer - 16'h0001;
      if (s.searching && s.timer == 16'(synth_pkg::LOCK_CYCLES)) begin
        next_s.searching = 1'b0;
        // simple band model: pick the band from the feedback ratio
        next_s.osc = s.regs[0][synth_pkg::N_LO+5:synth_pkg::N_LO];
      end
      if (s.timer == 16'h0001) begin
        next_s.locked = 1'b1;
      end
    end

    // ========================================================
    // serial shift
    // readback bits move on sclk rise; the host samples just before it
    if (sclk_rise) begin
      next_s.shift_in = {s.shift_in[30:0], link.sdata};
      if (s.out_count != '0) begin
        next_s.shift_out = {s.shift_out[30:0], 1'b0};
        next_s.out_count = s.out_count - 6'h01;
      end
    end

    // ========================================================
    // register latch and retune
    // addresses 6 and 7 are never stored
    if (le_rise) begin
      if (s.shift_in[2:0] <= synth_pkg::ADDR_LAST_WRITABLE) begin
        next_s.regs[s.shift_in[2:0]] = s.shift_in;
      end
      if (s.shift_in[2:0] == synth_pkg::ADDR_REG0) begin
        next_s.locked = 1'b0;
        if (s.regs[3][synth_pkg::AUTOSEL_DISABLE_BIT]) begin
          // manual band skips the search time entirely
          next_s.searching = 1'b0;
          next_s.osc = s.regs[3][synth_pkg::OSC_HI:synth_pkg::OSC_LO];
          next_s.timer = 16'(synth_pkg::LOCK_CYCLES);
        end else begin
          next_s.searching = 1'b1;
          next_s.timer = 16'(SEARCH_CYCLES + synth_pkg::LOCK_CYCLES);
        end
      end
      // readback word: die id, search flag, current band, address
      if (s.shift_in[2:0] == synth_pkg::ADDR_REG6) begin
        word6 = {synth_pkg::DIE_ID, 4'h0, 1'b0, 7'h00, 1'b0, 5'h00, s.searching, s.osc,
          synth_pkg::ADDR_REG6};
        next_s.shift_out = word6;
        next_s.out_count = synth_pkg::WORD_BITS_COUNT;
      end
    end

    // ========================================================
    // pin function and sync input
    // the device drives the pin only for the readback code
    pin_fn = {next_s.regs[5][synth_pkg::PIN_FN_MSB_BIT],
      next_s.regs[2][synth_pkg::PIN_FN_HI:synth_pkg::PIN_FN_LO]};
    next_s.mux_oe = (pin_fn == synth_pkg::PIN_FN_READBACK);
    // a sync edge counts in fractional mode only
    fractional = ~s.regs[0][synth_pkg::INT_MODE_BIT] & ~s.regs[5][synth_pkg::ZERO_FRAC_BIT];
    // sync edge restarts the divider phase in every device at once
    if (mux_rise && pin_fn == synth_pkg::PIN_FN_SYNC && fractional) begin
      next_s.phase = '0;
      next_s.synced = 1'b1;
      next_s.phase_applied = 1'b0;
    end

    // ========================================================
    // phase adjust
    // two writes: 10 arms the adjust, 00 loads the offset
    div_mode = s.regs[3][synth_pkg::DIV_MODE_HI:synth_pkg::DIV_MODE_LO];
    next_s.last_div_mode = div_mode;
    if (s.last_div_mode == synth_pkg::DIV_MODE_PHASE && div_mode == synth_pkg::DIV_MODE_OFF
        && s.synced) begin
      next_s.phase = s.regs[1][synth_pkg::PHASE_HI:synth_pkg::PHASE_LO];
      next_s.phase_applied = 1'b1;
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================
  // outputs
  assign link.lock_detect = s.locked;
  assign link.dev_mux_out = s.shift_out[31];
  assign link.dev_mux_oe = s.mux_oe;

  // observation ports for the bench
  assign locked = s.locked;
  assign osc_index = s.osc;
  assign output_phase = s.phase;
  assign synced = s.synced;
  assign phase_applied = s.phase_applied;
endmodule : synth_device

// ==== verif/synth_link_sva.sv ====
// checker for the synthesizer link: serial framing, lock timing and sync guards
// assumes one clock; instantiated beside the link interface, no bind
`timescale 1ns/1ps
module synth_link_sva #(
  parameter int SEARCH_CYCLES = synth_pkg::SEARCH_CYCLES
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic sclk,
  input wire logic sdata,
  input wire logic le,
  input wire logic lock_detect,
  input wire logic host_mux_out,
  input wire logic host_mux_oe,
  input wire logic dev_mux_oe,
  input wire logic mux_level
);
  // ==========
  // shadow of words seen on the wire
  // small margin on lock time: the device sees le in the same clock as this shadow
  localparam int LOCK_LO = synth_pkg::LOCK_CYCLES - 4;
  localparam int LOCK_HI = synth_pkg::LOCK_CYCLES + 8;
  logic sclk_q, le_q, manual;
  logic [31:0] sh, r0, r2, r3, r4, r5;
  logic [15:0] cnt;
  logic [3:0] fn;
  assign fn = {r5[18], r2[28:26]};
  always_ff @(posedge clk) begin
    if (!rstn) begin
      {sclk_q, le_q, manual, sh, r0, r2, r3, r4, r5, cnt} <= '0;
    end else begin
      sclk_q <= sclk;
      le_q <= le;
      cnt <= (cnt == 16'hffff) ? cnt : cnt + 16'h0001;
      if (sclk && !sclk_q) begin
        sh <= {sh[30:0], sdata};
      end
      if (le && !le_q) begin
        case (sh[2:0])
          3'h0: begin
            r0 <= sh;
            cnt <= 16'h0000;
            manual <= r3[25];
          end
          3'h2: r2 <= sh;
          3'h3: r3 <= sh;
          3'h4: r4 <= sh;
          3'h5: r5 <= sh;
          default: ;
        endcase
      end
    end
  end
  // ==========
  // properties
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_half(s);
    s[*5] ##1 !s;
  endsequence
  sequence s_sync_edge;
    $rose(mux_level) && host_mux_oe;
  endsequence
  a_le_one_half: assert property ($rose(le) |-> s_half(le))
    else $error("latch enable width wrong");
  a_sclk_one_half: assert property ($rose(sclk) |-> s_half(sclk))
    else $error("serial clock half period wrong");
  a_retune_drops_lock: assert property (
    $rose(le) && sh[2:0] == 3'h0 |-> ##[1:4] !lock_detect)
    else $error("reg0 write did not drop lock");
  a_manual_lock_time: assert property (
    $rose(lock_detect) && manual |-> cnt >= LOCK_LO && cnt <= LOCK_HI)
    else $error("manual band lock time wrong");
  a_auto_lock_time: assert property (
    $rose(lock_detect) && !manual |->
      cnt >= LOCK_LO + SEARCH_CYCLES && cnt <= LOCK_HI + SEARCH_CYCLES)
    else $error("searched band lock time wrong");
  a_sync_ref_path: assert property (
    s_sync_edge |-> r2[25:24] == 2'h0 && r2[23:14] == synth_pkg::RDIV_ONE)
    else $error("sync raised with bad reference path");
  a_sync_frac_mode: assert property (
    s_sync_edge |-> !r0[31] && !r5[24] && r2[30:29] == 2'h0 &&
      r0[30:15] > synth_pkg::N_MIN_EXCL && r0[30:15] < synth_pkg::N_MAX_EXCL)
    else $error("sync raised outside fractional setup");
  a_sync_divider: assert property (
    s_sync_edge |-> !r4[23] && !r4[9] && r4[22:20] <= synth_pkg::OUT_DIV_MAX)
    else $error("sync raised with bad divider setup");
  a_sync_when_locked: assert property (
    s_sync_edge |-> lock_detect && fn == synth_pkg::PIN_FN_SYNC)
    else $error("sync raised unlocked or pin not sync input");
  a_sync_pin_quiet: assert property (fn == synth_pkg::PIN_FN_SYNC |-> !dev_mux_oe)
    else $error("device drives pin in sync mode");
  a_readback_code: assert property (dev_mux_oe |-> fn == synth_pkg::PIN_FN_READBACK)
    else $error("device drives pin outside readback");
  a_release_low: assert property ($fell(host_mux_oe) |-> !$past(host_mux_out))
    else $error("pin released while high");
endmodule : synth_link_sva

// ==== verif/synth_vco_select_phase_sync_test.sv ====
// self-checking bench: host and device joined by the link interface
// assumes software reaches the host over avalon-mm; seed fixed at 13
`timescale 1ns/1ps
module synth_vco_select_phase_sync_test;
  localparam int SEARCH = 50;
  logic clk, rstn, read, write, waitrequest, locked, synced, phase_applied;
  logic [3:0] address;
  logic [31:0] writedata, readdata, q;
  logic [5:0] osc_index;
  logic [11:0] output_phase;
  logic [15:0] seed;
  int miscompares, n_compared;
  synth_link_if link();
  synth_host synth_host_i (.clk(clk), .rstn(rstn), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .link(link));
  synth_device #(.SEARCH_CYCLES(SEARCH)) synth_device_i (.clk(clk), .rstn(rstn),
    .link(link), .locked(locked), .osc_index(osc_index), .output_phase(output_phase),
    .synced(synced), .phase_applied(phase_applied));
  synth_link_sva #(.SEARCH_CYCLES(SEARCH)) chk_i (.clk(clk), .rstn(rstn),
    .sclk(link.sclk), .sdata(link.sdata), .le(link.le), .lock_detect(link.lock_detect),
    .host_mux_out(link.host_mux_out), .host_mux_oe(link.host_mux_oe),
    .dev_mux_oe(link.dev_mux_oe), .mux_level(link.mux_level));
  // ==========
  // helpers
  task automatic wrap_up();
    if (miscompares == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : wrap_up
  task automatic check(input string s, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", s, e, g);
    end
  endtask : check
  function automatic logic [15:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed;
  endfunction : rnd
  // held until waitrequest is seen low at an edge, released only after it
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= !wr;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 2000);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (waitrequest !== 1'b0) begin
      miscompares++;
      wrap_up();
    end
  endtask : bus
  task automatic wait_st(input logic [31:0] m, input logic [31:0] v);
    for (int i = 0; i < 1500; i++) begin
      bus(1'b0, synth_pkg::HOST_STATUS, 32'h0000_0000);
      if ((q & m) === v) break;
    end
    if ((q & m) !== v) begin
      miscompares++;
      wrap_up();
    end
  endtask : wait_st
  task automatic send(input logic [31:0] w);
    bus(1'b1, synth_pkg::HOST_TX, w);
    wait_st(32'h0000_0001, 32'h0000_0000);
  endtask : send
  // ==========
  // device words
  function automatic logic [31:0] w0(input logic [15:0] n);
    return {1'b0, n, 12'h000, 3'h0};
  endfunction : w0
  function automatic logic [31:0] w2(input logic [2:0] f);
    return {3'h0, f, 2'h0, synth_pkg::RDIV_ONE, 11'h000, 3'h2};
  endfunction : w2
  function automatic logic [31:0] w3(input logic [5:0] o, input logic [1:0] m);
    return {o, 1'b1, 8'h00, m, 12'h000, 3'h3};
  endfunction : w3
  function automatic logic [31:0] w5(input logic b);
    return {13'h0000, b, 15'h0000, 3'h5};
  endfunction : w5
  // ==========
  // stimulus
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    logic [15:0] ns [3];
    logic [5:0] tbl [3];
    logic [31:0] bad [12];
    logic [31:0] g4;
    logic [11:0] ph;
    seed = 16'h000d;
    rstn = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 4'h0;
    writedata = 32'h0000_0000;
    miscompares = 0;
    n_compared = 0;
    g4 = 32'h0040_0004;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    bus(1'b0, synth_pkg::HOST_STATUS, 32'h0000_0000);
    check("status", 32'h0000_0000, q);
    bus(1'b1, 4'h6, 32'hffff_ffff);
    bus(1'b0, 4'h2, 32'h0000_0000);
    check("unmapped", 32'h0000_0000, q);
    bus(1'b0, synth_pkg::HOST_CTRL, 32'h0000_0000);
    check("ctrl", 32'h0000_0000, q);
    // band table through autoselect and pin readback
    send(w2(3'h4));
    send(w5(1'b1));
    send(32'h0000_0003);
    for (int i = 0; i < 3; i++) begin
      ns[i] = (rnd() & 16'h03ff) | 16'h0040;
      tbl[i] = ns[i][5:0];
      send(w0(ns[i]));
      wait_st(32'h0000_0002, 32'h0000_0002);
      send(32'h0000_0006);
      bus(1'b0, synth_pkg::HOST_RX, 32'h0000_0000);
      check("readback", {synth_pkg::DIE_ID, 19'h0_0000, tbl[i], 3'h6}, q);
    end
    // manual band: search would pick the other band
    send(w3(tbl[1], 2'h0));
    send(w0(ns[1] ^ 16'h0001));
    wait_st(32'h0000_0002, 32'h0000_0002);
    check("manual band", 32'(tbl[1]), 32'(osc_index));
    check("locked", 32'h0000_0001, 32'(locked));
    // sync setup with boundary values, pin held low
    bus(1'b1, synth_pkg::HOST_CTRL, 32'h0000_0001);
    send(w5(1'b0));
    send(w2(3'h7));
    send(g4);
    send(w3(tbl[0], 2'h0));
    send(w0(16'h0014));
    wait_st(32'h0000_0002, 32'h0000_0002);
    bus(1'b0, synth_pkg::HOST_STATUS, 32'h0000_0000);
    check("sync ready", 32'h0000_0008, q & 32'h0000_0008);
    bad = '{w2(3'h7) ^ 32'h0200_0000, w2(3'h7) ^ 32'h0100_0000, w2(3'h7) ^ 32'h0000_8000,
      w2(3'h7) ^ 32'h2000_0000, g4 ^ 32'h0080_0000, g4 ^ 32'h0010_0000,
      w5(1'b0) ^ 32'h0100_0000, w0(16'h0013), w0(16'h0ffb),
      g4 ^ 32'h0000_0200,
      w3(tbl[0], 2'h0) ^ 32'h0200_0000,
      w0(16'h0014) ^ 32'h8000_0000};
    // each broken field must block the sync pulse; reg0 is not restored, so the two words after the bad ratios also run with a bad ratio
    for (int i = 0; i < 12; i++) begin
      send(bad[i]);
      bus(1'b1, synth_pkg::HOST_CTRL, 32'h0000_0003);
      bus(1'b0, synth_pkg::HOST_STATUS, 32'h0000_0000);
      check("guard", 32'h0000_0000, q & 32'h0000_000c);
      bus(1'b1, synth_pkg::HOST_CTRL, 32'h0000_0001);
      send(bad[i][2:0] == 3'h2 ? w2(3'h7) : bad[i][2:0] == 3'h4 ? g4 :
        bad[i][2:0] == 3'h3 ? w3(tbl[0], 2'h0) : w5(1'b0));
    end
    send(w0(16'h0014));
    wait_st(32'h0000_0002, 32'h0000_0002);
    bus(1'b1, synth_pkg::HOST_CTRL, 32'h0000_0003);
    wait_st(32'h0000_0004, 32'h0000_0004);
    check("synced", 32'h0000_0001, 32'(synced));
    ph = 12'(rnd());
    send({5'h00, ph, 12'h000, 3'h1});
    send(w3(tbl[0], synth_pkg::DIV_MODE_PHASE));
    check("early phase", 32'h0000_0000, 32'(phase_applied));
    send(w3(tbl[0], synth_pkg::DIV_MODE_OFF));
    check("phase applied", 32'h0000_0001, 32'(phase_applied));
    check("phase offset", 32'h0000_0001, 32'(12'(output_phase - ph) < 12'h040));
    // pin back to readback: low, high impedance, then released
    bus(1'b1, synth_pkg::HOST_CTRL, 32'h0000_0001);
    send(w2(3'h0));
    bus(1'b1, synth_pkg::HOST_CTRL, 32'h0000_0000);
    send(w2(3'h4));
    send(w5(1'b1));
    send(32'h0000_0006);
    bus(1'b0, synth_pkg::HOST_RX, 32'h0000_0000);
    check("reuse readback", {synth_pkg::DIE_ID, 19'h0_0000, tbl[0], 3'h6}, q);
    wrap_up();
  end
endmodule : synth_vco_select_phase_sync_test
